//--- src/pcg_gate_if.sv
// gating words from the register file and the deep sleep word input to the mode selector
`timescale 1ns/1ps
interface pcg_gate_if;
    pcg_pkg::pcg_units_t run_units;
    pcg_pkg::pcg_units_t sleep_units;
    pcg_pkg::pcg_units_t deep_units;
    logic                auto_gate;
    logic                sleep_req;
    logic                deep_req;
    pcg_pkg::pcg_units_t active_units;
    pcg_pkg::pcg_mode_e  mode;

    modport ctrl (
        output run_units, sleep_units, deep_units,
        output auto_gate, sleep_req, deep_req,
        input  active_units, mode
    );
    modport sel (
        input  run_units, sleep_units, deep_units,
        input  auto_gate, sleep_req, deep_req,
        output active_units, mode
    );
endinterface : pcg_gate_if

//--- src/pcg_gate_sel.sv
// power mode tracking and selection of the active gating word
`timescale 1ns/1ps
module pcg_gate_sel (
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    pcg_gate_if.sel   g
);

    pcg_pkg::pcg_mode_e  mode_reg;
    pcg_pkg::pcg_mode_e  mode_next;
    pcg_pkg::pcg_units_t active_reg;
    pcg_pkg::pcg_units_t active_next;

    always_comb
    begin
        if (g.deep_req)
            mode_next = pcg_pkg::PCG_DEEP;
        else if (g.sleep_req)
            mode_next = pcg_pkg::PCG_SLEEP;
        else
            mode_next = pcg_pkg::PCG_RUN;
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            mode_reg <= pcg_pkg::PCG_RUN;
        else
            mode_reg <= mode_next;
    end

    // word choice per mode; run word unless automatic gating in sleep or deep sleep
    always_comb
    begin
        case (mode_reg)
            pcg_pkg::PCG_SLEEP:
                active_next = g.auto_gate ? g.sleep_units
                                          : g.run_units;
            pcg_pkg::PCG_DEEP:
                active_next = g.auto_gate ? g.deep_units
                                          : g.run_units;
            default:
                active_next = g.run_units;
        endcase
    end

    // registered enables switch only on clock edges, glitch-free
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            active_reg <= pcg_pkg::UNITS_RST;
        else
            active_reg <= active_next;
    end

    assign g.active_units = active_reg;
    assign g.mode         = mode_reg;

endmodule : pcg_gate_sel

//--- src/pcg_pkg.sv
// constants, types and helpers for peripheral clock gating
package pcg_pkg;

    localparam int NUM_UNITS = 7;
    typedef logic [NUM_UNITS-1:0] pcg_units_t;

    // register offsets
    localparam logic [11:0] RUN_OFS    = 12'h104;
    localparam logic [11:0] SLEEP_OFS  = 12'h114;
    localparam logic [11:0] AUTO_OFS   = 12'h1F0;
    localparam logic [11:0] STATUS_OFS = 12'h1F4;

    // unit index in the packed enable vector
    localparam int U_UART = 0;
    localparam int U_SSI  = 1;
    localparam int U_I2C  = 2;
    localparam int U_T0   = 3;
    localparam int U_T1   = 4;
    localparam int U_T2   = 5;
    localparam int U_CMP  = 6;

    // bit positions within a gating word
    localparam int UNIT_POS [NUM_UNITS] = '{0, 4, 12, 16, 17, 18, 24};

    localparam logic [31:0] WORD_RST   = 32'h0000_0000;
    localparam logic [31:0] VALID_MASK = 32'h0107_1011;
    localparam pcg_units_t  UNITS_RST  = 7'h00;
    localparam logic [31:0] DATA_ZERO  = 32'h0000_0000;
    localparam int          AUTO_BIT   = 0;
    localparam int          STAT_MODE_LSB = 8;

    typedef enum logic [2:0] {
        PCG_RUN   = 3'b001,
        PCG_SLEEP = 3'b010,
        PCG_DEEP  = 3'b100
    } pcg_mode_e;

    function automatic pcg_units_t word_to_units(input logic [31:0] w);
        pcg_units_t u;
        u = UNITS_RST;
        for (int i = 0; i < NUM_UNITS; i++)
            u[i] = w[UNIT_POS[i]];
        return u;
    endfunction : word_to_units

    function automatic logic [31:0] units_to_word(input pcg_units_t u);
        logic [31:0] w;
        w = WORD_RST;
        for (int i = 0; i < NUM_UNITS; i++)
            w[UNIT_POS[i]] = u[i];
        return w;
    endfunction : units_to_word

endpackage : pcg_pkg

//--- src/pcg_top.sv
// peripheral clock gating registers, bus slave and access faulting
`timescale 1ns/1ps

module pcg_top (
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    input  wire logic        sleep_i,
    input  wire logic        deep_sleep_i,
    input  wire logic [31:0] deep_sleep_gate_word_i,
    input  wire logic [6:0]  periph_sel_i,
    output logic      [6:0]  periph_grant_o,
    output logic             bus_fault_o,
    output logic      [6:0]  unit_clk_en_o
);

    ////////////////////////////////////////////////////////////////////
    // declarations

    pcg_gate_if g ();

    pcg_pkg::pcg_units_t run_units_reg;
    pcg_pkg::pcg_units_t sleep_units_reg;
    logic                auto_gate_reg;
    logic [31:0]         dat_reg;
    logic [31:0]         dat_next;
    logic                ack_reg;
    logic                err_reg;
    logic                req_new;
    logic                hit_run;
    logic                hit_sleep;
    logic                hit_auto;
    logic                hit_stat;
    logic                mapped;
    logic [31:0]         wmask;
    logic                sleep_meta_reg;
    logic                sleep_sync_reg;
    logic                deep_meta_reg;
    logic                deep_sync_reg;
    logic [6:0]          grant_reg;
    logic                fault_reg;

    function automatic logic [31:0] lane_mask(input logic [3:0] sel);
        logic [31:0] m;
        m = pcg_pkg::DATA_ZERO;
        for (int b = 0; b < 4; b++)
            m[b*8 +: 8] = {8{sel[b]}};
        return m;
    endfunction : lane_mask

    function automatic pcg_pkg::pcg_units_t merge_units(
        input pcg_pkg::pcg_units_t old_u,
        input logic [31:0]         wdata,
        input logic [31:0]         mask
    );
        logic [31:0] w;
        w = (pcg_pkg::units_to_word(old_u) & ~mask) | (wdata & mask);
        return pcg_pkg::word_to_units(w);
    endfunction : merge_units

    ////////////////////////////////////////////////////////////////////
    // power mode inputs come from another domain

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            sleep_meta_reg <= 1'b0;
            sleep_sync_reg <= 1'b0;
            deep_meta_reg  <= 1'b0;
            deep_sync_reg  <= 1'b0;
        end
        else
        begin
            sleep_meta_reg <= sleep_i;
            sleep_sync_reg <= sleep_meta_reg;
            deep_meta_reg  <= deep_sleep_i;
            deep_sync_reg  <= deep_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // wishbone decode

    assign req_new   = wb_cyc_i && wb_stb_i && !ack_reg && !err_reg;
    assign wmask     = lane_mask(wb_sel_i);

    always_comb
    begin
        hit_run   = 1'b0;
        hit_sleep = 1'b0;
        hit_auto  = 1'b0;
        hit_stat  = 1'b0;
        if (wb_adr_i == pcg_pkg::RUN_OFS)
            hit_run = 1'b1;
        else if (wb_adr_i == pcg_pkg::SLEEP_OFS)
            hit_sleep = 1'b1;
        else if (wb_adr_i == pcg_pkg::AUTO_OFS)
            hit_auto = 1'b1;
        else if (wb_adr_i == pcg_pkg::STATUS_OFS)
            hit_stat = 1'b1;
    end

    assign mapped = hit_run || hit_sleep || hit_auto || hit_stat;

    // unused bits read as zero by construction of the word
    always_comb
    begin
        dat_next = pcg_pkg::DATA_ZERO;
        if (hit_run)
            dat_next = pcg_pkg::units_to_word(run_units_reg);
        else if (hit_sleep)
            dat_next = pcg_pkg::units_to_word(sleep_units_reg);
        else if (hit_auto)
            dat_next[pcg_pkg::AUTO_BIT] = auto_gate_reg;
        else if (hit_stat)
        begin
            dat_next[pcg_pkg::NUM_UNITS-1:0] = g.active_units;
            dat_next[pcg_pkg::STAT_MODE_LSB +: 3] = g.mode;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // bus handshake: one wait state, ack or err for one cycle

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            ack_reg <= 1'b0;
            err_reg <= 1'b0;
        end
        else
        begin
            ack_reg <= req_new && mapped;
            err_reg <= req_new && !mapped;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            dat_reg <= pcg_pkg::DATA_ZERO;
        else if (req_new && !wb_we_i)
            dat_reg <= dat_next;
        else
            dat_reg <= pcg_pkg::DATA_ZERO;
    end

    ////////////////////////////////////////////////////////////////////
    // gating word storage

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            run_units_reg <= pcg_pkg::UNITS_RST;
        else if (req_new && wb_we_i && hit_run)
            run_units_reg <= merge_units(run_units_reg, wb_dat_i,
                                         wmask);
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            sleep_units_reg <= pcg_pkg::UNITS_RST;
        else if (req_new && wb_we_i && hit_sleep)
            sleep_units_reg <= merge_units(sleep_units_reg, wb_dat_i,
                                           wmask);
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            auto_gate_reg <= 1'b0;
        else if (req_new && wb_we_i && hit_auto && wb_sel_i[0])
            auto_gate_reg <= wb_dat_i[pcg_pkg::AUTO_BIT];
    end

    ////////////////////////////////////////////////////////////////////
    // mode selector

    assign g.run_units   = run_units_reg;
    assign g.sleep_units = sleep_units_reg;
    assign g.deep_units  = pcg_pkg::word_to_units(deep_sleep_gate_word_i);
    assign g.auto_gate   = auto_gate_reg;
    assign g.sleep_req   = sleep_sync_reg;
    assign g.deep_req    = deep_sync_reg;

    pcg_gate_sel u_sel (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .g       (g.sel)
    );

    ////////////////////////////////////////////////////////////////////
    // peripheral access: pass when clocked, fault when gated

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            grant_reg <= pcg_pkg::UNITS_RST;
            fault_reg <= 1'b0;
        end
        else
        begin
            grant_reg <= periph_sel_i & g.active_units;
            fault_reg <= |(periph_sel_i & ~g.active_units);
        end
    end

    assign wb_dat_o       = dat_reg;
    assign wb_ack_o       = ack_reg;
    assign wb_err_o       = err_reg;
    assign periph_grant_o = grant_reg;
    assign bus_fault_o    = fault_reg;
    assign unit_clk_en_o  = g.active_units;

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    chk_reset_zero: assert property (
        disable iff (1'b0)
        !rst_b_i |=> run_units_reg == pcg_pkg::UNITS_RST
                     && sleep_units_reg == pcg_pkg::UNITS_RST
                     && unit_clk_en_o == pcg_pkg::UNITS_RST)
        else $error("gating words not zero after reset");

    chk_fault_gated: assert property (
        (|(periph_sel_i & ~unit_clk_en_o)) |=> bus_fault_o
            && (periph_grant_o & ~$past(unit_clk_en_o)) == pcg_pkg::UNITS_RST)
        else $error("access to gated unit gave no fault");

    chk_grant_clocked: assert property (
        (|periph_sel_i) |=>
            periph_grant_o == $past(periph_sel_i & unit_clk_en_o))
        else $error("grant does not follow clock enable");

    chk_run_word_use: assert property (
        g.mode == pcg_pkg::PCG_RUN ##1 g.mode == pcg_pkg::PCG_RUN
        |-> unit_clk_en_o == $past(run_units_reg))
        else $error("run mode not using run word");

    chk_sleep_auto: assert property (
        g.mode == pcg_pkg::PCG_SLEEP && auto_gate_reg
        |=> unit_clk_en_o == $past(sleep_units_reg))
        else $error("sleep word not applied with auto gating");

    chk_no_auto_run: assert property (
        !auto_gate_reg |=> unit_clk_en_o == $past(run_units_reg))
        else $error("run word not kept without auto gating");

    chk_deep_mode: assert property (
        deep_sleep_i [*3] |=> g.mode == pcg_pkg::PCG_DEEP)
        else $error("deep sleep not entered after sync delay");

    chk_run_write: assert property (
        req_new && wb_we_i && wb_adr_i == pcg_pkg::RUN_OFS
        && wb_sel_i == 4'hF |=> wb_ack_o
        && run_units_reg == pcg_pkg::word_to_units($past(wb_dat_i)))
        else $error("run word write lost");

    chk_sleep_write: assert property (
        req_new && wb_we_i && wb_adr_i == pcg_pkg::SLEEP_OFS
        && wb_sel_i == 4'hF |=> wb_ack_o
        && sleep_units_reg == pcg_pkg::word_to_units($past(wb_dat_i)))
        else $error("sleep word write lost");

    chk_reserved_zero: assert property (
        wb_ack_o && !wb_we_i
        && (wb_adr_i == pcg_pkg::RUN_OFS || wb_adr_i == pcg_pkg::SLEEP_OFS)
        |-> (wb_dat_o & ~pcg_pkg::VALID_MASK) == pcg_pkg::DATA_ZERO)
        else $error("reserved bits read nonzero");

    chk_timer_bit: assert property (
        wb_ack_o && !wb_we_i && wb_adr_i == pcg_pkg::RUN_OFS
        |-> wb_dat_o[16] == run_units_reg[pcg_pkg::U_T0]
            && wb_dat_o[12] == run_units_reg[pcg_pkg::U_I2C]
            && wb_dat_o[4] == run_units_reg[pcg_pkg::U_SSI]
            && wb_dat_o[0] == run_units_reg[pcg_pkg::U_UART]
            && wb_dat_o[17] == run_units_reg[pcg_pkg::U_T1]
            && wb_dat_o[18] == run_units_reg[pcg_pkg::U_T2]
            && wb_dat_o[24] == run_units_reg[pcg_pkg::U_CMP])
        else $error("gate bit positions wrong");

    chk_ack_single: assert property (
        wb_ack_o |=> !wb_ack_o && !wb_err_o)
        else $error("ack longer than one cycle");

    chk_deep_auto: assert property (
        g.mode == pcg_pkg::PCG_DEEP && auto_gate_reg
        |=> unit_clk_en_o == $past(g.deep_units))
        else $error("deep word not applied with auto gating");

    chk_sleep_mode: assert property (
        (sleep_i && !deep_sleep_i) [*3] |=> g.mode == pcg_pkg::PCG_SLEEP)
        else $error("sleep not entered after sync delay");

    chk_auto_write: assert property (
        req_new && wb_we_i && wb_adr_i == pcg_pkg::AUTO_OFS && wb_sel_i[0]
        |=> auto_gate_reg == $past(wb_dat_i[pcg_pkg::AUTO_BIT]))
        else $error("auto gating select write lost");

    chk_dat_idle: assert property (
        !wb_ack_o |-> wb_dat_o == pcg_pkg::DATA_ZERO)
        else $error("read data not zero outside ack");

    chk_err_unmapped: assert property (
        req_new && !mapped |=> wb_err_o && !wb_ack_o
            && $stable(run_units_reg) && $stable(sleep_units_reg))
        else $error("unmapped access not refused");

    cov_fault: cover property (bus_fault_o);
    cov_deep_auto: cover property (
        g.mode == pcg_pkg::PCG_DEEP && auto_gate_reg);
    cov_sleep_auto: cover property (
        g.mode == pcg_pkg::PCG_SLEEP && auto_gate_reg);
    cov_unmapped: cover property (wb_err_o);
    cov_grant: cover property (|periph_grant_o);

endmodule : pcg_top

//--- tb/pcg_top_tb.sv
// self-checking bench for the peripheral clock gating block
`timescale 1ns/1ps
module pcg_top_tb;
    logic        clk_i;
    logic        rst_b_i;
    logic        wb_cyc_i;
    logic        wb_stb_i;
    logic        wb_we_i;
    logic [11:0] wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        wb_err_o;
    logic        sleep_i;
    logic        deep_sleep_i;
    logic [31:0] deep_sleep_gate_word_i;
    logic [6:0]  periph_sel_i;
    logic [6:0]  periph_grant_o;
    logic        bus_fault_o;
    logic [6:0]  unit_clk_en_o;
    int          n_mismatch;
    int          num_checks;
    int          seed;
    logic [31:0] run_m;
    logic [31:0] sleep_m;
    logic        auto_m;
    logic        sl_m;
    logic        dp_m;
    logic [31:0] rd;
    logic [31:0] wd;
    logic [31:0] lane;
    logic [11:0] adr;
    logic [3:0]  sel;
    logic        er;

    pcg_top pcg_top_i (
        .clk_i                  (clk_i),
        .rst_b_i                (rst_b_i),
        .wb_cyc_i               (wb_cyc_i),
        .wb_stb_i               (wb_stb_i),
        .wb_we_i                (wb_we_i),
        .wb_adr_i               (wb_adr_i),
        .wb_sel_i               (wb_sel_i),
        .wb_dat_i               (wb_dat_i),
        .wb_dat_o               (wb_dat_o),
        .wb_ack_o               (wb_ack_o),
        .wb_err_o               (wb_err_o),
        .sleep_i                (sleep_i),
        .deep_sleep_i           (deep_sleep_i),
        .deep_sleep_gate_word_i (deep_sleep_gate_word_i),
        .periph_sel_i           (periph_sel_i),
        .periph_grant_o         (periph_grant_o),
        .bus_fault_o            (bus_fault_o),
        .unit_clk_en_o          (unit_clk_en_o)
    );

    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] exp,
                         input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run

    // unit enables of a gating word, by the package bit positions
    function automatic logic [6:0] units(input logic [31:0] w);
        logic [6:0] u;
        u = 7'h00;
        for (int i = 0; i < 7; i++)
            u[i] = w[pcg_pkg::UNIT_POS[i]];
        return u;
    endfunction : units

    function automatic logic [6:0] act_m();
        if (auto_m && dp_m)
            return units(deep_sleep_gate_word_i);
        if (auto_m && sl_m)
            return units(sleep_m);
        return units(run_m);
    endfunction : act_m

    function automatic logic [31:0] stat_m();
        logic [2:0] m;
        m = dp_m ? 3'h4 : (sl_m ? 3'h2 : 3'h1);
        return {21'h0, m, 1'b0, act_m()};
    endfunction : stat_m

    task automatic wb_xfer(input logic we, input logic [11:0] a,
                           input logic [3:0] s, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
        if (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1)
        begin
            n_mismatch++;
            $display("MISMATCH bus_answer expected 1 seen 0");
            complete_run();
        end
        else
        begin
            // answer sampled at this edge; release right after it
            rd = wb_dat_o;
            er = wb_err_o;
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
            wb_we_i  <= 1'b0;
        end
    endtask : wb_xfer

    task automatic access_chk();
        logic [6:0] s;
        s = 7'($random(seed));
        @(posedge clk_i);
        periph_sel_i <= s;
        @(posedge clk_i);
        @(negedge clk_i);
        check("grant", {25'h0, s & act_m()}, {25'h0, periph_grant_o});
        check("fault", {31'h0, |(s & ~act_m())}, {31'h0, bus_fault_o});
        check("clk_en", {25'h0, act_m()}, {25'h0, unit_clk_en_o});
    endtask : access_chk

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        seed = 32'hF6D7DD60;
        n_mismatch = 0;
        num_checks = 0;
        rst_b_i = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 12'h000;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0000_0000;
        sleep_i = 1'b0;
        deep_sleep_i = 1'b0;
        deep_sleep_gate_word_i = 32'h0000_0000;
        periph_sel_i = 7'h00;
        run_m = 32'h0;
        sleep_m = 32'h0;
        auto_m = 1'b0;
        sl_m = 1'b0;
        dp_m = 1'b0;
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1'b1;
        // reset values
        wb_xfer(1'b0, pcg_pkg::RUN_OFS, 4'hF, 32'h0);
        check("run_reset", 32'h0, rd);
        wb_xfer(1'b0, pcg_pkg::SLEEP_OFS, 4'hF, 32'h0);
        check("sleep_reset", 32'h0, rd);
        wb_xfer(1'b0, pcg_pkg::AUTO_OFS, 4'hF, 32'h0);
        check("auto_reset", 32'h0, rd);
        wb_xfer(1'b0, pcg_pkg::STATUS_OFS, 4'hF, 32'h0);
        check("status_reset", stat_m(), rd);
        access_chk();
        $display("test reset done");
        // byte-lane writes with read-back, all ones first
        for (int i = 0; i < 24; i++)
        begin
            adr = (i % 2) ? pcg_pkg::SLEEP_OFS : pcg_pkg::RUN_OFS;
            sel = (i < 2) ? 4'hF : 4'($random(seed));
            wd = (i < 2) ? 32'hFFFF_FFFF : 32'($random(seed));
            lane = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
            wb_xfer(1'b1, adr, sel, wd);
            check("wr_err", 32'h0, {31'h0, er});
            if (i % 2)
                sleep_m = ((sleep_m & ~lane) | (wd & lane)) & 32'h0107_1011;
            else
                run_m = ((run_m & ~lane) | (wd & lane)) & 32'h0107_1011;
            wb_xfer(1'b0, adr, 4'hF, 32'h0);
            check("word", (i % 2) ? sleep_m : run_m, rd);
            access_chk();
        end
        $display("test words done");
        // unmapped offset and read-only status
        wb_xfer(1'b1, 12'h108, 4'hF, 32'hFFFF_FFFF);
        check("unmapped_err", 32'h1, {31'h0, er});
        wb_xfer(1'b1, pcg_pkg::STATUS_OFS, 4'hF, 32'hFFFF_FFFF);
        wb_xfer(1'b0, pcg_pkg::STATUS_OFS, 4'hF, 32'h0);
        check("status_ro", stat_m(), rd);
        wb_xfer(1'b0, pcg_pkg::RUN_OFS, 4'hF, 32'h0);
        check("run_kept", run_m, rd);
        $display("test refusal done");
        // every combination of auto gating, sleep and deep sleep
        for (int i = 0; i < 16; i++)
        begin
            auto_m = i[0];
            wb_xfer(1'b1, pcg_pkg::AUTO_OFS, 4'hF, {31'h0, auto_m});
            @(posedge clk_i);
            sleep_i <= i[1];
            deep_sleep_i <= i[2];
            deep_sleep_gate_word_i <= 32'($random(seed));
            sl_m = i[1];
            dp_m = i[2];
            repeat (6) @(posedge clk_i);
            access_chk();
            wb_xfer(1'b0, pcg_pkg::STATUS_OFS, 4'hF, 32'h0);
            check("status_mode", stat_m(), rd);
        end
        $display("test modes done");
        // reset in mid-run clears both words and the mode
        @(posedge clk_i);
        rst_b_i <= 1'b0;
        periph_sel_i <= 7'h00;
        sleep_i <= 1'b0;
        deep_sleep_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1'b1;
        run_m = 32'h0;
        sleep_m = 32'h0;
        auto_m = 1'b0;
        sl_m = 1'b0;
        dp_m = 1'b0;
        wb_xfer(1'b0, pcg_pkg::RUN_OFS, 4'hF, 32'h0);
        check("run_rerst", 32'h0, rd);
        wb_xfer(1'b0, pcg_pkg::SLEEP_OFS, 4'hF, 32'h0);
        check("sleep_rerst", 32'h0, rd);
        wb_xfer(1'b0, pcg_pkg::STATUS_OFS, 4'hF, 32'h0);
        check("status_rerst", stat_m(), rd);
        access_chk();
        $display("test mid reset done");
        complete_run();
    end
endmodule : pcg_top_tb
